// [common/air_mac_pkg.sv]
// shared constants, message codes and check function for the polled air link
package air_mac_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned OPEN_PERIOD_MS = 100;
  localparam int unsigned OPEN_PERIOD_CYC = OPEN_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned POLL_PERIOD_MS = 2;
  localparam int unsigned POLL_PERIOD_CYC = POLL_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned SLOT_NS = 400;
  localparam int unsigned SLOT_CYC = (SLOT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NUM_SLOTS = 16;
  localparam int unsigned WINDOW_CYC = NUM_SLOTS * SLOT_CYC;
  localparam int unsigned RX_WAIT_CYC = 16;
  localparam int unsigned GUARD_CYC = 1024;
  // ----------------------------------------------------------------
  // sizes and limits
  // ----------------------------------------------------------------
  localparam int unsigned MAX_SUBS = 252;
  localparam int unsigned NFRAG = 4;
  localparam int unsigned IDX_W = 2;
  localparam int unsigned MAX_RETRY = 4;
  localparam int unsigned BURST_MAX = 4;
  localparam logic [7:0] BCAST_ADDR = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] LFSR_SEED = 8'h5a;
  // ----------------------------------------------------------------
  // requirement score layout: class, queued count, urgency
  // ----------------------------------------------------------------
  localparam int unsigned SC_CLASS = 7;
  localparam int unsigned SC_QCNT_HI = 6;
  localparam int unsigned SC_QCNT_LO = 3;
  localparam int unsigned SC_URG_HI = 2;
  // ----------------------------------------------------------------
  // message codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DN_OPEN = 2'h0,
    DN_CTS = 2'h1,
    DN_ACK = 2'h2,
    DN_NONE = 2'h3
  } dn_type_t;
  typedef enum logic [1:0] {
    UP_RTS = 2'h0,
    UP_HDR = 2'h1,
    UP_FRAG = 2'h2,
    UP_NONE = 2'h3
  } up_type_t;

  // check byte over one message byte
  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = d;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
endpackage : air_mac_pkg

// [common/air_link_if.sv]
// shared air channel between the base radio and a subscriber radio
interface air_link_if;
  // ----------------------------------------------------------------
  // downlink: base to subscribers
  // ----------------------------------------------------------------
  logic dn_valid;
  air_mac_pkg::dn_type_t dn_type;
  logic [7:0] dn_addr;
  logic [air_mac_pkg::NFRAG-1:0] dn_mask;
  logic [7:0] dn_crc;
  // ----------------------------------------------------------------
  // uplink: subscribers to base
  // ----------------------------------------------------------------
  logic up_valid;
  air_mac_pkg::up_type_t up_type;
  logic [7:0] up_addr;
  logic [air_mac_pkg::IDX_W-1:0] up_idx;
  logic [7:0] up_data;
  logic [7:0] up_crc;

  modport base (
    output dn_valid, dn_type, dn_addr, dn_mask, dn_crc,
    input up_valid, up_type, up_addr, up_idx, up_data, up_crc
  );
  modport sub (
    input dn_valid, dn_type, dn_addr, dn_mask, dn_crc,
    output up_valid, up_type, up_addr, up_idx, up_data, up_crc
  );
endinterface : air_link_if

// [rtl/two_entry_buffer.sv]
// two-entry valid/ready buffer with registered outputs
module two_entry_buffer #(
  parameter int unsigned W = 17
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic spare_valid;
  logic [W-1:0] spare_data;
  wire head_free = out_ready_i || !out_valid_o;

  // spare slot catches the word that arrives while the head is stalled
  assign in_ready_o = !spare_valid;

  // ----------------------------------------------------------------
  // head and spare registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      spare_valid <= 1'b0;
      spare_data <= '0;
    end
    else if (head_free)
    begin
      if (spare_valid)
      begin
        out_data_o <= spare_data;
        spare_valid <= 1'b0;
      end
      else
      begin
        out_valid_o <= in_valid_i;
        out_data_o <= in_data_i;
      end
    end
    else if (in_valid_i && in_ready_o)
    begin
      spare_data <= in_data_i;
      spare_valid <= 1'b1;
    end
  end
endmodule : two_entry_buffer

// [rtl/base_radio.sv]
// base radio end: contention window, ranking, polling, fragment check, delivery
module base_radio #(
  parameter int unsigned OPEN_CYC = air_mac_pkg::OPEN_PERIOD_CYC,
  parameter int unsigned POLL_CYC = air_mac_pkg::POLL_PERIOD_CYC
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  air_link_if.base air,
  input wire logic periodic_mode_i,
  input wire logic burst_en_i,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_addr_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  output logic [15:0] poll_cnt_o
);
  localparam int unsigned NF = air_mac_pkg::NFRAG;
  localparam int unsigned QH = air_mac_pkg::SC_QCNT_HI;
  localparam int unsigned QL = air_mac_pkg::SC_QCNT_LO;

  typedef enum logic [2:0] {
    ST_OPEN = 3'h0,
    ST_WINDOW = 3'h1,
    ST_RANK = 3'h2,
    ST_HOLD = 3'h3,
    ST_GRANT = 3'h4,
    ST_RECV = 3'h5,
    ST_ACK = 3'h6,
    ST_DELIVER = 3'h7
  } state_t;

  state_t state;
  logic [7:0] score_tab [air_mac_pkg::MAX_SUBS];
  logic [7:0] frag_mem [NF];
  logic [15:0] win_cnt;
  logic [7:0] scan_idx;
  logic [7:0] best_idx;
  logic [7:0] best_score;
  logic [7:0] cur;
  logic [7:0] rr_ptr;
  logic [7:0] rx_tmr;
  logic [NF-1:0] err_mask;
  logic [air_mac_pkg::IDX_W-1:0] del_idx;
  logic [2:0] retry_cnt;
  logic [2:0] burst_cnt;
  logic hdr_empty;
  logic [31:0] open_cnt;
  logic open_due;
  logic [31:0] poll_tmr;
  logic poll_due;
  logic dn_valid;
  air_mac_pkg::dn_type_t dn_type;
  logic [7:0] dn_addr;
  logic [NF-1:0] dn_mask;
  logic buf_ready;

  // ----------------------------------------------------------------
  // uplink decode
  // ----------------------------------------------------------------
  wire up_ok = air.up_valid && (air.up_crc == air_mac_pkg::crc8(air.up_data));
  wire up_mine = up_ok && (air.up_addr == cur);
  wire rts_hit = (state == ST_WINDOW) && up_ok && (air.up_type == air_mac_pkg::UP_RTS)
                 && (air.up_addr < 8'(air_mac_pkg::MAX_SUBS));
  wire hdr_hit = (state == ST_RECV) && up_mine && (air.up_type == air_mac_pkg::UP_HDR);
  wire frag_hit = (state == ST_RECV) && up_mine && (air.up_type == air_mac_pkg::UP_FRAG);

  // ranking: class bit is the score msb, so class 1 traffic wins the compare
  wire [7:0] scan_score = score_tab[scan_idx];
  wire scan_better = scan_score > best_score;
  wire [7:0] final_idx = scan_better ? scan_idx : best_idx;
  wire [7:0] final_score = scan_better ? scan_score : best_score;
  wire scan_last = scan_idx == 8'(air_mac_pkg::MAX_SUBS - 1);
  wire [7:0] cur_score = score_tab[cur];
  wire [3:0] cur_backlog = cur_score[QH:QL];
  wire grant_ok = !open_due;

  // delivery path into the buffer
  wire del_last = del_idx == air_mac_pkg::IDX_W'(NF - 1);
  wire push = (state == ST_DELIVER) && buf_ready;
  wire del_end = push && del_last;

  assign air.dn_valid = dn_valid;
  assign air.dn_type = dn_type;
  assign air.dn_addr = dn_addr;
  assign air.dn_mask = dn_mask;
  assign air.dn_crc = air_mac_pkg::crc8(dn_addr);

  // ----------------------------------------------------------------
  // open period and periodic poll timers
  // ----------------------------------------------------------------
  // guard leaves room for a scan and a poll to finish before the deadline
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      open_cnt <= '0;
      open_due <= 1'b0;
    end
    else
    begin
      open_cnt <= (state == ST_OPEN) ? 32'h0 : open_cnt + 32'h1;
      if (open_cnt == 32'(OPEN_CYC - air_mac_pkg::GUARD_CYC))
        open_due <= 1'b1;
      else if (state == ST_OPEN)
        open_due <= 1'b0;
    end
  end

  // poll tick for periodic mode; a new tick beats the clear
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      poll_tmr <= '0;
      poll_due <= 1'b0;
    end
    else
    begin
      poll_tmr <= (poll_tmr == 32'(POLL_CYC - 1)) ? 32'h0 : poll_tmr + 32'h1;
      if (poll_tmr == 32'(POLL_CYC - 1))
        poll_due <= 1'b1;
      else if (state == ST_HOLD && periodic_mode_i && !open_due)
        poll_due <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // requirement table
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < int'(air_mac_pkg::MAX_SUBS); i++)
        score_tab[i] <= '0;
    end
    else if (rts_hit)
      score_tab[air.up_addr] <= air.up_data;
    else if (hdr_hit)
      score_tab[cur] <= air.up_data;
    else if (del_end && cur_backlog <= 4'h1)
      score_tab[cur] <= '0;
  end

  // ----------------------------------------------------------------
  // fragment store; the error map is kept by the scheduler
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < int'(NF); i++)
        frag_mem[i] <= '0;
    end
    else if (frag_hit)
      frag_mem[air.up_idx] <= air.up_data;
  end

  // ----------------------------------------------------------------
  // scheduler
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_OPEN;
      win_cnt <= '0;
      scan_idx <= '0;
      best_idx <= '0;
      best_score <= '0;
      cur <= '0;
      rr_ptr <= '0;
      rx_tmr <= '0;
      err_mask <= '1;
      del_idx <= '0;
      retry_cnt <= '0;
      burst_cnt <= '0;
      hdr_empty <= 1'b0;
      dn_valid <= 1'b0;
      dn_type <= air_mac_pkg::DN_NONE;
      dn_addr <= air_mac_pkg::BCAST_ADDR;
      dn_mask <= '0;
      poll_cnt_o <= '0;
    end
    else
    begin
      dn_valid <= 1'b0;
      case (state)
        ST_OPEN:
        begin
          dn_valid <= 1'b1;
          dn_type <= air_mac_pkg::DN_OPEN;
          dn_addr <= air_mac_pkg::BCAST_ADDR;
          dn_mask <= '0;
          win_cnt <= '0;
          state <= ST_WINDOW;
        end
        ST_WINDOW:
        begin
          win_cnt <= win_cnt + 16'h1;
          if (win_cnt == 16'(air_mac_pkg::WINDOW_CYC - 1))
          begin
            state <= ST_RANK;
            scan_idx <= '0;
            best_score <= '0;
          end
        end
        ST_RANK:
        begin
          scan_idx <= scan_idx + 8'h1;
          best_idx <= final_idx;
          best_score <= final_score;
          if (scan_last)
          begin
            if (final_score != 8'h0 && grant_ok)
            begin
              cur <= final_idx;
              err_mask <= '1;
              retry_cnt <= '0;
              burst_cnt <= '0;
              state <= ST_GRANT;
            end
            else
              state <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (open_due)
            state <= ST_OPEN;
          else if (!periodic_mode_i)
          begin
            scan_idx <= '0;
            best_score <= '0;
            state <= ST_RANK;
          end
          else if (poll_due)
          begin
            cur <= rr_ptr;
            rr_ptr <= scan_last_rr(rr_ptr);
            err_mask <= '1;
            retry_cnt <= '0;
            burst_cnt <= '0;
            state <= ST_GRANT;
          end
        end
        ST_GRANT:
        begin
          dn_valid <= 1'b1;
          dn_type <= air_mac_pkg::DN_CTS;
          dn_addr <= cur;
          dn_mask <= err_mask;
          poll_cnt_o <= poll_cnt_o + 16'h1;
          rx_tmr <= '0;
          hdr_empty <= 1'b0;
          state <= ST_RECV;
        end
        ST_RECV:
        begin
          rx_tmr <= rx_tmr + 8'h1;
          if (frag_hit)
            err_mask[air.up_idx] <= 1'b0;
          if (hdr_hit && air.up_data[QH:QL] == 4'h0)
            hdr_empty <= 1'b1;
          if (rx_tmr == 8'(air_mac_pkg::RX_WAIT_CYC - 1))
            state <= ST_ACK;
        end
        ST_ACK:
        begin
          dn_valid <= 1'b1;
          dn_type <= air_mac_pkg::DN_ACK;
          dn_addr <= cur;
          dn_mask <= err_mask;
          if (hdr_empty)
            state <= ST_HOLD;
          else if (err_mask == '0)
          begin
            del_idx <= '0;
            state <= ST_DELIVER;
          end
          else if (retry_cnt != 3'(air_mac_pkg::MAX_RETRY - 1) && grant_ok)
          begin
            retry_cnt <= retry_cnt + 3'h1;
            state <= ST_GRANT;
          end
          else
            state <= ST_HOLD;
        end
        ST_DELIVER:
        begin
          if (push)
            del_idx <= del_idx + 1'b1;
          if (del_end)
          begin
            if (burst_en_i && cur_backlog > 4'h1 && grant_ok
                && burst_cnt != 3'(air_mac_pkg::BURST_MAX - 1))
            begin
              burst_cnt <= burst_cnt + 3'h1;
              err_mask <= '1;
              retry_cnt <= '0;
              state <= ST_GRANT;
            end
            else
              state <= ST_HOLD;
          end
        end
        default:
          state <= ST_OPEN;
      endcase
    end
  end

  // round-robin successor, wraps after the last subscriber
  function automatic logic [7:0] scan_last_rr(input logic [7:0] a);
    return (a == 8'(air_mac_pkg::MAX_SUBS - 1)) ? 8'h0 : a + 8'h1;
  endfunction : scan_last_rr

  // ----------------------------------------------------------------
  // delivery buffer: only fully acknowledged packets reach it
  // ----------------------------------------------------------------
  two_entry_buffer #(
    .W(17)
  ) two_entry_buffer_i (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(state == ST_DELIVER),
    .in_ready_o(buf_ready),
    .in_data_i({cur, frag_mem[del_idx], del_last}),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o({rx_addr_o, rx_data_o, rx_last_o})
  );
endmodule : base_radio

// [rtl/subscriber_radio.sv]
// subscriber radio end: slotted requests, fragment send and resend
module subscriber_radio (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  air_link_if.sub air,
  input wire logic [7:0] my_addr_i,
  input wire logic qos_class_i,
  input wire logic [3:0] qcount_i,
  input wire logic [7:0] ttl_i,
  input wire logic pkt_valid_i,
  input wire logic [8*air_mac_pkg::NFRAG-1:0] pkt_data_i,
  output logic pkt_done_o
);
  localparam int unsigned NF = air_mac_pkg::NFRAG;

  typedef enum logic [1:0] {
    SS_IDLE = 2'h0,
    SS_CONTEND = 2'h1,
    SS_SEND = 2'h2,
    SS_WAIT = 2'h3
  } sub_state_t;

  sub_state_t state;
  logic [7:0] lfsr;
  logic [3:0] pick_a;
  logic [3:0] pick_b;
  logic [7:0] slot_cyc;
  logic [4:0] slot_num;
  logic [NF-1:0] mask;
  logic [2:0] step;
  logic known;
  logic up_valid;
  air_mac_pkg::up_type_t up_type;
  logic [air_mac_pkg::IDX_W-1:0] up_idx;
  logic [7:0] up_data;

  // ----------------------------------------------------------------
  // downlink decode; messages failing the check are ignored
  // ----------------------------------------------------------------
  wire dn_ok = air.dn_valid && (air.dn_crc == air_mac_pkg::crc8(air.dn_addr));
  wire to_me = dn_ok && (air.dn_addr == my_addr_i);
  wire open_hit = dn_ok && (air.dn_type == air_mac_pkg::DN_OPEN);
  wire cts_hit = to_me && (air.dn_type == air_mac_pkg::DN_CTS);
  wire ack_hit = to_me && (air.dn_type == air_mac_pkg::DN_ACK);
  // less time to live means more urgency
  wire [7:0] score = {qos_class_i, qcount_i, ~ttl_i[7:5]};
  wire [7:0] hdr_score = pkt_valid_i ? score : 8'h0;
  wire slot_start = (slot_cyc == 8'h0)
                    && (slot_num[3:0] == pick_a || slot_num[3:0] == pick_b);
  wire slot_end = slot_cyc == 8'(air_mac_pkg::SLOT_CYC - 1);
  wire [air_mac_pkg::IDX_W-1:0] fidx = air_mac_pkg::IDX_W'(step - 3'h1);
  wire send_last = step == 3'(NF);

  assign air.up_valid = up_valid;
  assign air.up_type = up_type;
  assign air.up_addr = my_addr_i;
  assign air.up_idx = up_idx;
  assign air.up_data = up_data;
  assign air.up_crc = air_mac_pkg::crc8(up_data);

  // ----------------------------------------------------------------
  // slot picker
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lfsr <= air_mac_pkg::LFSR_SEED;
    else
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end

  // ----------------------------------------------------------------
  // request, send and acknowledge sequence
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= SS_IDLE;
      pick_a <= '0;
      pick_b <= '0;
      slot_cyc <= '0;
      slot_num <= '0;
      mask <= '0;
      step <= '0;
      known <= 1'b0;
      up_valid <= 1'b0;
      up_type <= air_mac_pkg::UP_NONE;
      up_idx <= '0;
      up_data <= '0;
      pkt_done_o <= 1'b0;
    end
    else
    begin
      up_valid <= 1'b0;
      pkt_done_o <= 1'b0;
      case (state)
        SS_IDLE, SS_CONTEND:
        begin
          if (cts_hit)
          begin
            mask <= pkt_valid_i ? air.dn_mask : '0;
            step <= '0;
            state <= SS_SEND;
          end
          else if (state == SS_IDLE)
          begin
            // a fresh window restarts contention for packets the last header did not report as backlog
            if (open_hit && pkt_valid_i && !known)
            begin
              pick_a <= lfsr[3:0] ^ my_addr_i[3:0];
              pick_b <= lfsr[7:4];
              slot_cyc <= '0;
              slot_num <= '0;
              state <= SS_CONTEND;
            end
          end
          else
          begin
            slot_cyc <= slot_end ? 8'h0 : slot_cyc + 8'h1;
            if (slot_end)
              slot_num <= slot_num + 5'h1;
            if (slot_start)
            begin
              up_valid <= 1'b1;
              up_type <= air_mac_pkg::UP_RTS;
              up_data <= score;
            end
            if (slot_end && slot_num == 5'(air_mac_pkg::NUM_SLOTS - 1))
              state <= SS_IDLE;
          end
        end
        SS_SEND:
        begin
          step <= step + 3'h1;
          if (step == 3'h0)
          begin
            up_valid <= 1'b1;
            up_type <= air_mac_pkg::UP_HDR;
            up_data <= hdr_score;
            known <= hdr_score[air_mac_pkg::SC_QCNT_HI:air_mac_pkg::SC_QCNT_LO] > 4'h1;
          end
          else if (mask[fidx])
          begin
            up_valid <= 1'b1;
            up_type <= air_mac_pkg::UP_FRAG;
            up_idx <= fidx;
            up_data <= pkt_data_i[8*fidx +: 8];
          end
          if (send_last)
            state <= SS_WAIT;
        end
        SS_WAIT:
        begin
          if (ack_hit)
          begin
            pkt_done_o <= pkt_valid_i && (air.dn_mask == '0);
            state <= SS_IDLE;
          end
          else if (open_hit)
            state <= SS_IDLE;
        end
        default:
          state <= SS_IDLE;
      endcase
    end
  end
endmodule : subscriber_radio

// [bench/air_mac_checker.sv]
// concurrent checks on the air link between base and subscriber
module air_mac_checker #(
  parameter int unsigned OPEN_CYC = 4000,
  parameter logic [7:0] SUB_ADDR = 8'h03
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic dn_valid,
  input wire air_mac_pkg::dn_type_t dn_type,
  input wire logic [7:0] dn_addr,
  input wire logic [3:0] dn_mask,
  input wire logic [7:0] dn_crc,
  input wire logic up_valid,
  input wire air_mac_pkg::up_type_t up_type,
  input wire logic [7:0] up_addr,
  input wire logic [1:0] up_idx,
  input wire logic [7:0] up_data,
  input wire logic [7:0] up_crc
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire is_open = dn_valid && dn_type == air_mac_pkg::DN_OPEN;
  wire is_cts = dn_valid && dn_type == air_mac_pkg::DN_CTS;
  wire is_ack = dn_valid && dn_type == air_mac_pkg::DN_ACK;
  wire is_rts = up_valid && up_type == air_mac_pkg::UP_RTS;
  wire is_hdr = up_valid && up_type == air_mac_pkg::UP_HDR;
  int unsigned win_cnt;
  int unsigned since_open;
  logic [3:0] grant_mask;
  // window position 1..1280, cycles since open, last granted fragments
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      win_cnt <= 0;
      since_open <= 0;
      grant_mask <= 4'h0;
    end
    else
    begin
      win_cnt <= is_open ? 1 : (win_cnt != 0 && win_cnt < 1280) ? win_cnt + 1 : 0;
      since_open <= is_open ? 0 : since_open + 1;
      grant_mask <= is_cts ? dn_mask : grant_mask;
    end
  end
  a_open_bcast: assert property (is_open |-> dn_addr == 8'hff)
    else $error("open not broadcast");
  a_open_interval: assert property (since_open < OPEN_CYC)
    else $error("open interval too long");
  a_window_quiet: assert property (dn_valid |-> win_cnt == 0)
    else $error("downlink inside window");
  a_rts_slot_edge: assert property (is_rts |-> win_cnt >= 2 && (win_cnt - 2) % 80 == 0)
    else $error("request off slot start");
  a_up_after_open: assert property (is_open |=> !up_valid)
    else $error("uplink right after open");
  a_hdr_after_cts: assert property (is_cts && dn_addr == SUB_ADDR |-> ##2 is_hdr)
    else $error("no header after grant");
  a_frag_in_grant: assert property (up_valid && up_type == air_mac_pkg::UP_FRAG |->
    grant_mask[up_idx]) else $error("fragment not granted");
  a_ack_after_hdr: assert property (is_hdr && up_data[6:3] != 0 |->
    ##15 is_ack && dn_addr == $past(up_addr, 15)) else $error("ack missing");
  c_rts: cover property (is_rts);
  c_cts: cover property (is_cts);
  c_ack_clean: cover property (is_ack && dn_mask == 4'h0);
endmodule : air_mac_checker

// [bench/polled_air_mac_scheduler_tb_top.sv]
// bench top: base and subscriber radios joined over one air link
module polled_air_mac_scheduler_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
  logic mclk_i = 0, rst_n_i = 0, per_mode = 0, burst_en = 0, rx_rdy = 0, pkt_v = 0, qos = 1;
  logic rx_v, rx_l, done;
  logic [7:0] rx_a, rx_d, addr = 8'h03, ttl = 8'h10;
  logic [3:0] qcnt = 4'h1;
  logic [31:0] pkt = 32'h0;
  logic [15:0] polls;
  int err_total = 0, n_compared = 0, cyc = 0;
  bit got_done;
  air_link_if lnk ();
  base_radio #(.OPEN_CYC(4000), .POLL_CYC(300)) base_radio_i (.mclk_i, .rst_n_i, .air(lnk),
    .periodic_mode_i(per_mode), .burst_en_i(burst_en), .rx_valid_o(rx_v), .rx_ready_i(rx_rdy),
    .rx_addr_o(rx_a), .rx_data_o(rx_d), .rx_last_o(rx_l), .poll_cnt_o(polls));
  subscriber_radio subscriber_radio_i (.mclk_i, .rst_n_i, .air(lnk), .my_addr_i(addr),
    .qos_class_i(qos), .qcount_i(qcnt), .ttl_i(ttl), .pkt_valid_i(pkt_v), .pkt_data_i(pkt),
    .pkt_done_o(done));
  air_mac_checker #(.OPEN_CYC(4000), .SUB_ADDR(8'h03)) air_mac_checker_i (.mclk_i, .rst_n_i,
    .dn_valid(lnk.dn_valid), .dn_type(lnk.dn_type), .dn_addr(lnk.dn_addr),
    .dn_mask(lnk.dn_mask), .dn_crc(lnk.dn_crc), .up_valid(lnk.up_valid),
    .up_type(lnk.up_type), .up_addr(lnk.up_addr), .up_idx(lnk.up_idx),
    .up_data(lnk.up_data), .up_crc(lnk.up_crc));
  initial forever #2.5 mclk_i = ~mclk_i;
  // hang ceiling; done pulse latched since it stands only one cycle
  always @(posedge mclk_i)
  begin
    cyc++;
    if (done === 1'b1) got_done = 1;
    if (cyc == 40000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask : step
  // hand a packet over, stall the consumer, then take its four bytes
  task automatic send_pkt(input logic [31:0] d, input int stall);
    int w;
    w = 0;
    pkt = d;
    pkt_v = 1'b1;
    got_done = 0;
    while (rx_v !== 1'b1 && w < 8000)
    begin
      step();
      w++;
    end
    repeat (stall) step();
    for (int k = 0; k < 4; k++)
    begin
      `CHK(rx_v, 1'b1)
      `CHK(rx_d, d[8*k+:8])
      `CHK(rx_a, addr)
      `CHK(rx_l, k == 3)
      // ready stays up across the four bytes, so no same-step toggle
      rx_rdy = 1'b1;
      step();
    end
    rx_rdy = 1'b0;
    `CHK(got_done, 1'b1)
  endtask : send_pkt
  task automatic t_scored();
    logic [15:0] p0;
    p0 = polls;
    send_pkt(32'h4433_2211, 6);
    `CHK(polls, p0 + 16'h1)
    $display("t_scored done");
  endtask : t_scored
  // second packet rides on the header count, no new window in between
  task automatic t_burst();
    int t0;
    burst_en = 1'b1;
    qcnt = 4'h2;
    send_pkt(32'ha5c3_0ff0, 0);
    qcnt = 4'h1;
    t0 = cyc;
    send_pkt(32'h1e2d_3c4b, 0);
    `CHK(cyc - t0 < 400, 1'b1)
    $display("t_burst done");
  endtask : t_burst
  task automatic t_periodic();
    logic [15:0] p0;
    p0 = polls;
    per_mode = 1'b1;
    burst_en = 1'b0;
    send_pkt(32'h7788_99aa, 2);
    // round robin reaches us after three silent addresses, each tried fully
    `CHK(polls, p0 + 16'(3 * air_mac_pkg::MAX_RETRY + 1))
    pkt_v = 1'b0;
    $display("t_periodic done");
  endtask : t_periodic
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (4) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    // inputs move only from the first edge after release
    step();
    t_scored();
    t_burst();
    t_periodic();
    close_out();
  end
endmodule : polled_air_mac_scheduler_tb_top
